// file: rtl/msa_sequencer.sv
// conversion sequencer of a multiple-slope integrating converter
// assumes clk is the oscillator input and all host pins are asynchronous
module msa_sequencer
  import msa_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // host strobes and selects
  input  wire logic       modeSelect,
  input  wire logic       chipSelect,
  input  wire logic       chipEnableN,
  input  wire logic       writeN,
  input  wire logic       readN,
  input  wire logic       byteSelectLow,
  input  wire logic       ovrPolSelect,
  // comparator from the analog section
  input  wire logic       comparator,
  // analog switch controls
  output logic            swInputGate,
  output logic            swZeroLoop,
  output logic            swNegToCommon,
  output logic            swPrimaryRefCap,
  output logic            swSecondaryRefCap,
  // end of conversion
  output logic            busy,
  // data bus, three-state as data plus enable
  output logic [7:0]      dataOut,
  output logic            dataOe
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;

  assign pinRaw[SI_MODE]   = modeSelect;
  assign pinRaw[SI_CS]     = chipSelect;
  assign pinRaw[SI_CEN]    = chipEnableN;
  assign pinRaw[SI_WRN]    = writeN;
  assign pinRaw[SI_RDN]    = readN;
  assign pinRaw[SI_LOWB]   = byteSelectLow;
  assign pinRaw[SI_OVRPOL] = ovrPolSelect;
  assign pinRaw[SI_COMP]   = comparator;

  msa_sync #(.W(SYNC_W)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  ////////////////////////////////////////////////////////////////////////
  // selection and strobe decode
  wire modeCont = pinSync[SI_MODE];
  wire chipSel  = pinSync[SI_CS] & ~pinSync[SI_CEN];
  wire wrActive = chipSel & ~pinSync[SI_WRN];
  wire rdActive = chipSel & ~pinSync[SI_RDN];
  wire compIn   = pinSync[SI_COMP];

  logic wrActive_r;
  // trigger is the start of a selected low write pulse
  wire  wrPulse = wrActive & ~wrActive_r;

  ////////////////////////////////////////////////////////////////////////
  // clock divider
  logic [1:0] div_r;
  wire tick = (div_r == DIV_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing state and counters
  msa_state_e state_r;
  msa_state_e state_nxt;
  logic [9:0]  sub_r;        // clocks spent in current subphase
  logic [10:0] cyc_r;        // clocks since the cycle began
  logic [1:0]  ovrIdx_r;     // overrange subphase index
  logic        pol_r;        // comparator level after signal phase
  logic        stopped_r;    // current subphase has crossed zero
  logic        fastFull_r;   // fast subphase ran its full budget
  logic [9:0]  fastCnt_r;    // second counter set: result counts
  logic [6:0]  slowCnt_r;
  logic [7:0]  ovrCnt_r;
  logic        trigPend_r;   // demand trigger taken only in idle, waiting for a tick

  wire [9:0] budget =
    (state_r == ST_ZERO)   ? ZERO_CLKS   :
    (state_r == ST_SIGNAL) ? SIG_CLKS    :
    (state_r == ST_SETTLE) ? SETTLE_CLKS :
    (state_r == ST_FAST)   ? FAST_CLKS   :
    (state_r == ST_SLOW)   ? SLOW_CLKS   : OVR_CLKS;
  wire subEnd    = (sub_r == budget - 10'd1);
  wire lastOvr   = (ovrIdx_r == OVR_PHASES - 2'd1);
  wire cycleEnd  = tick && (state_r == ST_OVR) && subEnd && lastOvr;
  wire startConv = modeCont | trigPend_r;
  wire crossed   = (compIn != pol_r);

  always_comb begin
    state_nxt = state_r;
    if (tick) begin
      case (state_r)
        ST_IDLE: begin
          if (startConv) begin
            state_nxt = ST_ZERO;
          end
        end
        ST_ZERO: begin
          if (subEnd) begin
            state_nxt = ST_SIGNAL;
          end
        end
        ST_SIGNAL: begin
          if (subEnd) begin
            state_nxt = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (subEnd) begin
            state_nxt = ST_FAST;
          end
        end
        ST_FAST: begin
          if (subEnd) begin
            state_nxt = ST_SLOW;
          end
        end
        ST_SLOW: begin
          if (subEnd) begin
            state_nxt = ST_OVR;
          end
        end
        ST_OVR: begin
          // back to back in continuous mode
          if (subEnd && lastOvr) begin
            state_nxt = startConv ? ST_ZERO : ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // phase state and subphase timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      sub_r    <= 10'h000;
      ovrIdx_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (tick) begin
        sub_r <= (subEnd || state_r == ST_IDLE) ? 10'h000
                                                : sub_r + 10'h001;
        if (state_r == ST_OVR && subEnd) begin
          ovrIdx_r <= lastOvr ? 2'h0 : ovrIdx_r + 2'h1;
        end
      end
    end
  end

  // cycle position; drives busy timing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_r <= 11'h000;
    end else if (tick) begin
      if (state_r == ST_IDLE || cycleEnd) begin
        cyc_r <= 11'h000;
      end else begin
        cyc_r <= cyc_r + 11'h001;
      end
    end
  end

  // demand trigger; set wins, consumed when a cycle starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrActive_r <= 1'b0;
      trigPend_r <= 1'b0;
    end else begin
      wrActive_r <= wrActive;
      if (wrPulse && !modeCont && state_r == ST_IDLE) begin
        trigPend_r <= 1'b1;
      end else if (tick && state_r == ST_IDLE) begin
        trigPend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // deintegration counting
  wire inRef = (state_r == ST_FAST) || (state_r == ST_SLOW) ||
               (state_r == ST_OVR);
  // overrange only if fast never overshot, which leaves slow at zero
  wire countEn = tick && inRef && !stopped_r && !crossed &&
                 !((state_r == ST_OVR) &&
                   !(fastFull_r && slowCnt_r == 7'h00));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pol_r      <= 1'b0;
      stopped_r  <= 1'b0;
      fastFull_r <= 1'b0;
      fastCnt_r  <= 10'h000;
      slowCnt_r  <= 7'h00;
      ovrCnt_r   <= 8'h00;
    end else if (tick) begin
      if (state_r == ST_SIGNAL && subEnd) begin
        pol_r <= compIn;
      end
      if (state_r == ST_SETTLE) begin
        stopped_r  <= 1'b0;
        fastFull_r <= 1'b0;
        fastCnt_r  <= 10'h000;
        slowCnt_r  <= 7'h00;
        ovrCnt_r   <= 8'h00;
      end else if (inRef && subEnd) begin
        // each subphase starts counting afresh; idle time keeps length
        stopped_r <= 1'b0;
        if (state_r == ST_FAST) begin
          fastFull_r <= !crossed && !stopped_r;
          pol_r      <= ~pol_r;
        end else if (state_r == ST_SLOW) begin
          pol_r <= ~pol_r;
        end
      end else if (inRef && crossed) begin
        stopped_r <= 1'b1;
      end
      if (countEn) begin
        case (state_r)
          ST_FAST: fastCnt_r <= fastCnt_r + 10'h001;
          ST_SLOW: slowCnt_r <= slowCnt_r + 7'h01;
          default: ovrCnt_r <= ovrCnt_r + 8'h01;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result assembly
  // fast weights 64, slow refines
  wire [15:0] fastWeighted = {fastCnt_r, 6'h00};
  wire [15:0] magnitude    = fastWeighted - {9'h000, slowCnt_r}
                             + {8'h00, ovrCnt_r};
  wire        overrange    = (magnitude >= FULL_SCALE);

  logic [14:0] result_r;
  logic        resPol_r;
  logic        resOvr_r;

  // latch at cycle end with busy fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= 15'h0000;
      resPol_r <= 1'b0;
      resOvr_r <= 1'b0;
    end else if (cycleEnd) begin
      result_r <= magnitude[MAG_BITS-1:0];
      resPol_r <= pol_r;
      resOvr_r <= overrange;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch controls and busy, all registered
  wire zeroSt = (state_r == ST_ZERO);
  wire sigSt  = (state_r == ST_SIGNAL);
  wire busyNxt = (state_r != ST_IDLE) && !cycleEnd &&
                 (cyc_r >= BUSY_START - 11'd1) &&
                 !(cyc_r == BUSY_START - 11'd1 && !tick);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swInputGate       <= 1'b0;
      swZeroLoop        <= 1'b0;
      swNegToCommon     <= 1'b0;
      swPrimaryRefCap   <= 1'b0;
      swSecondaryRefCap <= 1'b0;
      busy              <= 1'b0;
    end else begin
      swZeroLoop        <= zeroSt;
      swInputGate       <= sigSt;
      swNegToCommon     <= zeroSt || inRef || (state_r == ST_SETTLE);
      swPrimaryRefCap   <= (state_r == ST_FAST);
      swSecondaryRefCap <= (state_r == ST_SLOW) || (state_r == ST_OVR);
      busy              <= busyNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 8-bit registered read bus
  wire       bit7   = pinSync[SI_OVRPOL] ? resOvr_r : resPol_r;
  wire [7:0] rdByte = pinSync[SI_LOWB] ? result_r[7:0]
                                       : {bit7, result_r[14:8]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      dataOut <= rdByte;
      dataOe  <= rdActive;
    end
  end

endmodule

// file: rtl/msa_pkg.sv
// constants shared by the multislope converter sequencer files
// assumes one 100 MHz clock that stands in for the oscillator input
package msa_pkg;

  // clock divider between oscillator and internal counters
  localparam int unsigned DIV_RATIO   = 4;
  localparam logic [1:0]  DIV_LAST    = 2'h3;

  // phase budgets in internal (divided) clocks
  localparam logic [9:0]  ZERO_CLKS   = 10'd246;
  localparam logic [9:0]  SIG_CLKS    = 10'd256;
  localparam logic [9:0]  SETTLE_CLKS = 10'd10;
  localparam logic [9:0]  FAST_CLKS   = 10'd512;
  localparam logic [9:0]  SLOW_CLKS   = 10'd64;
  localparam logic [9:0]  OVR_CLKS    = 10'd64;
  localparam logic [1:0]  OVR_PHASES  = 2'd3;
  localparam logic [10:0] REF_CLKS    = 11'd778;
  localparam logic [10:0] CYCLE_CLKS  = 11'd1280;
  localparam logic [10:0] BUSY_CLKS   = 11'd836;
  localparam logic [10:0] BUSY_START  = CYCLE_CLKS - BUSY_CLKS;

  // result layout: fast count weights 64, slow count weights 1
  localparam int unsigned SLOW_BITS   = 6;
  localparam int unsigned MAG_BITS    = 15;
  localparam logic [15:0] FULL_SCALE  = 16'h8000;

  // number of synchronised pin inputs and their positions
  localparam int unsigned SYNC_W      = 8;
  localparam int unsigned SI_MODE     = 0;
  localparam int unsigned SI_CS       = 1;
  localparam int unsigned SI_CEN      = 2;
  localparam int unsigned SI_WRN      = 3;
  localparam int unsigned SI_RDN      = 4;
  localparam int unsigned SI_LOWB     = 5;
  localparam int unsigned SI_OVRPOL   = 6;
  localparam int unsigned SI_COMP     = 7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ZERO, ST_SIGNAL, ST_SETTLE, ST_FAST, ST_SLOW, ST_OVR
  } msa_state_e;

endpackage

// file: rtl/msa_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels; reset value is zero
module msa_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////
  // one two-stage chain per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_r[i]  <= asyncIn[i];
          syncOut[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule

// file: bench/msa_seq_asserts.sv
// port checks for the multislope sequencer, bound to its top module
// assumes one clock domain with an asynchronous active-high reset
module msa_seq_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host pins
  input wire logic chipSelect,
  input wire logic chipEnableN,
  input wire logic readN,
  // switches and status
  input wire logic swInputGate,
  input wire logic swZeroLoop,
  input wire logic swNegToCommon,
  input wire logic swPrimaryRefCap,
  input wire logic swSecondaryRefCap,
  input wire logic busy,
  input wire logic dataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        readSel;
  logic [3:0]  lvl;
  logic [12:0] cnt_r [4];
  assign readSel = chipSelect & ~chipEnableN & ~readN;
  assign lvl     = {busy, swZeroLoop, swInputGate, swPrimaryRefCap};
  //////////////////////////////////////////////////////////////////////////
  // high-time counters, cleared while low so each phase is timed alone
  always_ff @(posedge clk or posedge rst) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        cnt_r[i] <= 13'h0;
      end else begin
        cnt_r[i] <= lvl[i] ? cnt_r[i] + 13'h1 : 13'h0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sigEnd;
    $fell(swInputGate);
  endsequence
  sequence fastEnd;
    $fell(swPrimaryRefCap);
  endsequence
  a_busy_high_len: assert property (
    $fell(busy) |-> cnt_r[3] == 13'hd10) else $error("busy high time");
  a_zero_len: assert property (
    $fell(swZeroLoop) |-> cnt_r[2] == 13'h3d8) else $error("zero length");
  a_signal_len: assert property (
    sigEnd |-> cnt_r[1] == 13'h400) else $error("signal length");
  a_zero_then_sig: assert property (
    $fell(swZeroLoop) |-> swInputGate) else $error("phase order");
  a_busy_rise_at: assert property (
    $rose(busy) |-> swInputGate && cnt_r[1] inside {[13'h314:13'h31c]})
    else $error("busy rise moment");
  a_settle_fast: assert property (
    sigEnd |-> swNegToCommon ##[36:44] swPrimaryRefCap)
    else $error("settle then fast");
  a_fast_budget: assert property (
    fastEnd |-> cnt_r[0] <= 13'h800) else $error("fast too long");
  a_fast_to_slow: assert property (
    fastEnd |-> ##[0:4] swSecondaryRefCap) else $error("no slow");
  a_switch_apart: assert property (
    !(swPrimaryRefCap && swSecondaryRefCap) && !(swZeroLoop && swInputGate))
    else $error("switch overlap");
  a_read_on: assert property (
    readSel [*5] |-> dataOe) else $error("bus not driven");
  a_read_off: assert property (
    !readSel [*5] |-> !dataOe) else $error("bus not released");
endmodule

bind msa_sequencer msa_seq_asserts msa_seq_asserts_i (
  .clk, .rst, .chipSelect, .chipEnableN, .readN, .swInputGate, .swZeroLoop,
  .swNegToCommon, .swPrimaryRefCap, .swSecondaryRefCap, .busy, .dataOe);

// file: bench/msa_host_model.sv
// host processor model: drives selects and strobes of the sequencer
// assumes the bench calls its tasks; pins change at the falling edge
module msa_host_model (
  // clock and returned bus
  input wire logic       clk,
  input wire logic [7:0] dataOut,
  input wire logic       dataOe,
  // selects and strobes
  output logic           modeSelect,
  output logic           chipSelect,
  output logic           chipEnableN,
  output logic           writeN,
  output logic           readN,
  output logic           byteSelectLow,
  output logic           ovrPolSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: nothing selected, strobes high
  initial begin
    modeSelect    = 1'b0;
    chipSelect    = 1'b0;
    chipEnableN   = 1'b1;
    writeN        = 1'b1;
    readN         = 1'b1;
    byteSelectLow = 1'b0;
    ovrPolSelect  = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // mode level held
  task automatic setMode(input logic m);
    @(negedge clk);
    modeSelect = m;
  endtask
  task automatic trig(input logic cs, input logic cen);
    @(negedge clk);
    chipSelect  = cs;
    chipEnableN = cen;
    writeN      = 1'b0;
    repeat (2) @(negedge clk);
    writeN      = 1'b1;
    chipSelect  = 1'b0;
    chipEnableN = 1'b1;
  endtask
  // read once settled; the bench calls it after busy falls
  task automatic rd(input logic low, input logic ovr, output logic [7:0] d,
                    output logic oe);
    @(negedge clk);
    byteSelectLow = low;
    ovrPolSelect  = ovr;
    chipSelect    = 1'b1;
    chipEnableN   = 1'b0;
    readN         = 1'b0;
    repeat (5) @(negedge clk);
    d             = dataOut;
    oe            = dataOe;
    readN         = 1'b1;
    chipSelect    = 1'b0;
    chipEnableN   = 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the multislope sequencer, demand and continuous
// assumes the host model drives the pins and the checker is bound
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, negIn, oe;
  logic       comparator = 1'b0;
  logic       modeSelect, chipSelect, chipEnableN, writeN, readN;
  logic       byteSelectLow, ovrPolSelect, busy, dataOe;
  logic       swInputGate, swZeroLoop, swNegToCommon;
  logic       swPrimaryRefCap, swSecondaryRefCap;
  logic [7:0] dataOut, d, e;
  int         fails, tests_run, seed, inM, n;
  int         q = 0;
  int         ph = -1;
  msa_sequencer msa_sequencer_i (.clk, .rst, .modeSelect, .chipSelect,
    .chipEnableN, .writeN, .readN, .byteSelectLow, .ovrPolSelect,
    .comparator, .swInputGate, .swZeroLoop, .swNegToCommon,
    .swPrimaryRefCap, .swSecondaryRefCap, .busy, .dataOut, .dataOe);
  msa_host_model msa_host_model_i (.clk, .dataOut, .dataOe, .modeSelect,
    .chipSelect, .chipEnableN, .writeN, .readN, .byteSelectLow,
    .ovrPolSelect);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // integrator in half-lsb units; the offset keeps in-range crossings
  // off exact counts, stepping once per internal clock from fast start
  always @(posedge clk) begin
    if (swInputGate) begin
      q  = 2 * inM + ((inM < 32768) ? 1 : 0);
      ph = -1;
    end else if (ph >= 0 || swPrimaryRefCap) begin
      ph++;
      if (ph % 4 == 0) begin
        if (ph < 2048) begin
          if (swPrimaryRefCap && q > 0) q -= 128;
        end else if (swSecondaryRefCap) begin
          if (ph < 2304 && q < 0) q += 2;
          if (ph >= 2304 && q > 0) q -= 2;
        end
      end
    end
  end
  always @(negedge clk) comparator <= (q > 0) ^ negIn;
  //////////////////////////////////////////////////////////////////////////
  task automatic waitBusy(input logic v);
    int k = 0;
    while (busy !== v && k < 6000) begin
      @(negedge clk);
      n++;
      k++;
    end
  endtask
  // one demand conversion, optionally with a refused trigger inside it
  task automatic convert(input int m, input logic ng, input logic late);
    logic [15:0] mg;
    mg = m[15:0];
    @(negedge clk);
    inM   = m;
    negIn = ng;
    msa_host_model_i.trig(1'b1, 1'b0);
    waitBusy(1'b1);
    n = late ? 3 : 0;
    if (late) msa_host_model_i.trig(1'b1, 1'b0);
    waitBusy(1'b0);
    `CHK(n, 3344)
    msa_host_model_i.rd(1'b0, 1'b0, d, oe);
    `CHK(d, {~ng, mg[14:8]})
    `CHK(oe, 1'b1)
    msa_host_model_i.rd(1'b0, 1'b1, d, oe);
    `CHK(d, {mg[15], mg[14:8]})
    e = mg[7:0];
    msa_host_model_i.rd(1'b1, 1'b0, d, oe);
    `CHK(d, e)
    `CHK(swZeroLoop, 1'b0)
  endtask
  task automatic close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed       = 32'h094b;
    rst        = 1'b1;
    inM        = 0;
    negIn      = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK({busy, dataOe, swZeroLoop}, 3'h0)
    msa_host_model_i.trig(1'b1, 1'b1);
    msa_host_model_i.trig(1'b0, 1'b0);
    repeat (12) @(negedge clk);
    `CHK(swZeroLoop, 1'b0)
    convert(0, 1'b0, 1'b0);
    convert(32767, 1'b0, 1'b1);
    convert(32868, 1'b0, 1'b0);
    convert(1234, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) convert($random(seed) & 32'h7fff, i[0], 1'b0);
    repeat (400) @(negedge clk);
    msa_host_model_i.rd(1'b1, 1'b0, d, oe);
    `CHK(d, e)
    msa_host_model_i.setMode(1'b1);
    waitBusy(1'b1);
    waitBusy(1'b0);
    n = 0;
    waitBusy(1'b1);
    waitBusy(1'b0);
    `CHK(n, 5120)
    msa_host_model_i.setMode(1'b0);
    waitBusy(1'b1);
    waitBusy(1'b0);
    repeat (12) @(negedge clk);
    `CHK(swZeroLoop, 1'b0)
    close_out;
  end
  // about 52k clocks of work; the limit leaves wide margin
  initial begin
    #800000;
    fails++;
    close_out;
  end
endmodule
